// File: apm_pkg.sv
package apm_pkg;

    // Register offsets on the plain register port
    localparam logic [3:0] APM_MODE_OFS = 4'h0;
    localparam logic [3:0] APM_BLOCK_OFS = 4'h4;
    localparam logic [3:0] APM_RESET_OFS = 4'h8;
    localparam logic [3:0] APM_STATUS_OFS = 4'hC;

    // Mode control field positions
    localparam int APM_MODE_PS_LSB = 0;
    localparam int APM_MODE_RDIS_BIT = 2;
    localparam int APM_MODE_BYP_BIT = 3;
    localparam int APM_MODE_MONO_BIT = 4;

    // Mode control reset value: zero power, regulator mode, no bypass, stereo
    localparam logic [7:0] APM_MODE_RST = 8'h00;
    // Block control reset value: every block deselected
    localparam logic [7:0] APM_BLOCK_RST = 8'h00;

    // Power state field codes
    localparam logic [1:0] APM_PS_ZERO = 2'h0;
    localparam logic [1:0] APM_PS_STANDBY = 2'h1;
    localparam logic [1:0] APM_PS_OPER = 2'h2;

    // Decoded power state
    typedef enum logic [1:0] {
        APM_ZERO,
        APM_STANDBY,
        APM_OPER
    } apm_state_e;

    // Mode control register layout
    typedef struct packed {
        logic [2:0] spare;
        logic mono_select;
        logic regulator_bypass;
        logic regulator_disable_select;
        logic [1:0] power_state_field;
    } apm_mode_s;

    // Block control register layout
    typedef struct packed {
        logic headphone_common_enable;
        logic hp_right_sel;
        logic hp_left_sel;
        logic earpiece_sel;
        logic speaker_sel;
        logic aux_sel;
        logic ain_sel;
        logic dac_sel;
    } apm_block_s;

    // Enables driven to the analog and datapath blocks
    typedef struct packed {
        logic regulator_enable;
        logic bypass_switch_close;
        logic charge_pump_enable;
        logic reference_bias_enable;
        logic dac_left_enable;
        logic dac_right_enable;
        logic right_sample_discard;
        logic ain_enable;
        logic aux_enable;
        logic speaker_enable;
        logic earpiece_enable;
        logic hp_left_enable;
        logic hp_right_enable;
        logic right_hp_from_left;
        logic headphone_common_output;
    } apm_ctrl_s;

    localparam apm_ctrl_s APM_CTRL_OFF = '0;

endpackage

// File: apm_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

// Three-stage pin synchroniser; output follows once stages two and three agree
module apm_pin_sync (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic pin_in,
    output logic pin_out
);

    logic meta_reg; // First stage, read only by the second
    logic s2_reg; // Second stage
    logic s3_reg; // Third stage

    // Shift chain; idle level of the pin is high
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
        end else if (ce) begin
            meta_reg <= pin_in;
            s2_reg <= meta_reg;
            s3_reg <= s2_reg;
        end
    end

    // Accept a new level only when two stages agree
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out <= 1'b1;
        end else if (ce && (s2_reg == s3_reg)) begin
            pin_out <= s3_reg;
        end
    end

endmodule

`default_nettype wire

// File: apm_power_ctrl.sv
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

module apm_power_ctrl
    import apm_pkg::*;
#(
    parameter int ADDR_W = 4,
    parameter int DATA_W = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic hardware_reset_pin_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    output apm_ctrl_s ctrl_out,
    output apm_state_e power_state
);

    apm_mode_s mode_reg; // Mode control register
    apm_block_s block_reg; // Block control register
    apm_ctrl_s ctrl_next; // Next block enables
    apm_state_e state_next; // Decoded state from mode register
    logic pin_level; // Filtered reset pin level
    logic soft_clear; // Return registers to defaults
    logic byp_active; // Bypass switch actually closed
    logic wr_mode; // Write to mode register
    logic wr_block; // Write to block register
    logic wr_reset; // Write to reset register

    // Decode the power field; the fourth code falls back to zero power
    function automatic apm_state_e decode_state(input logic [1:0] field);
        apm_state_e st;
        st = APM_ZERO;
        unique case (field)
            APM_PS_STANDBY: st = APM_STANDBY;
            APM_PS_OPER: st = APM_OPER;
            default: st = APM_ZERO;
        endcase
        return st;
    endfunction

    // Register address match
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] ofs);
        return a == ADDR_W'(ofs);
    endfunction

    // Reset pin comes from outside the clock domain
    apm_pin_sync u_pin_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ce(ce),
        .pin_in(hardware_reset_pin_n),
        .pin_out(pin_level)
    );

    // Write decode
    assign wr_mode = reg_wr && hit(reg_addr, APM_MODE_OFS);
    assign wr_block = reg_wr && hit(reg_addr, APM_BLOCK_OFS);
    assign wr_reset = reg_wr && hit(reg_addr, APM_RESET_OFS);

    // Pin held low or any reset register write clears the registers
    assign soft_clear = !pin_level || wr_reset;

    // Mode control register; writable in every state
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= apm_mode_s'(APM_MODE_RST);
        end else if (ce) begin
            if (soft_clear) begin
                mode_reg <= apm_mode_s'(APM_MODE_RST);
            end else if (wr_mode) begin
                mode_reg <= apm_mode_s'(reg_wdata[7:0]);
                mode_reg.spare <= 3'h0;
            end
        end
    end

    // Block control register; kept intact across state changes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            block_reg <= apm_block_s'(APM_BLOCK_RST);
        end else if (ce) begin
            if (soft_clear) begin
                block_reg <= apm_block_s'(APM_BLOCK_RST);
            end else if (wr_block) begin
                block_reg <= apm_block_s'(reg_wdata[7:0]);
            end
        end
    end

    // Effective state and bypass
    always_comb begin
        state_next = decode_state(mode_reg.power_state_field);
        // Bypass only allowed outside operational
        byp_active = mode_reg.regulator_bypass && (state_next != APM_OPER);
    end

    // Derive every block enable from state and control registers
    always_comb begin
        ctrl_next = APM_CTRL_OFF;
        ctrl_next.bypass_switch_close = byp_active;
        if (state_next != APM_ZERO) begin
            // Regulator runs unless disabled or bypassed
            ctrl_next.regulator_enable = !mode_reg.regulator_disable_select && !byp_active;
            // Charge pump only in non-regulator mode
            ctrl_next.charge_pump_enable = mode_reg.regulator_disable_select;
            ctrl_next.reference_bias_enable = 1'b1;
        end
        if (state_next == APM_OPER) begin
            // Block control becomes transparent
            ctrl_next.dac_left_enable = block_reg.dac_sel;
            ctrl_next.dac_right_enable = block_reg.dac_sel && !mode_reg.mono_select;
            ctrl_next.right_sample_discard = mode_reg.mono_select;
            ctrl_next.ain_enable = block_reg.ain_sel;
            ctrl_next.aux_enable = block_reg.aux_sel;
            ctrl_next.speaker_enable = block_reg.speaker_sel;
            ctrl_next.earpiece_enable = block_reg.earpiece_sel;
            ctrl_next.hp_left_enable = block_reg.hp_left_sel;
            ctrl_next.hp_right_enable = block_reg.hp_right_sel;
            ctrl_next.right_hp_from_left = mode_reg.mono_select;
            // Common driver on with either headphone side
            ctrl_next.headphone_common_output = block_reg.headphone_common_enable
                && (block_reg.hp_left_sel || block_reg.hp_right_sel);
        end
    end

    // Registered block enables
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_out <= APM_CTRL_OFF;
        end else if (ce) begin
            ctrl_out <= ctrl_next;
        end
    end

    // Registered power state
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            power_state <= APM_ZERO;
        end else if (ce) begin
            power_state <= state_next;
        end
    end

    // Read data stands in the cycle after the strobe only
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (ce) begin
            reg_rdata <= '0;
            if (reg_rd) begin
                if (hit(reg_addr, APM_MODE_OFS)) begin
                    reg_rdata <= DATA_W'(mode_reg);
                end else if (hit(reg_addr, APM_BLOCK_OFS)) begin
                    reg_rdata <= DATA_W'(block_reg);
                end else if (hit(reg_addr, APM_STATUS_OFS)) begin
                    // Live state: state code, regulator, bypass, pump, bias
                    reg_rdata <= DATA_W'({ctrl_out.reference_bias_enable, ctrl_out.charge_pump_enable,
                        ctrl_out.bypass_switch_close, ctrl_out.regulator_enable, 2'h0, power_state});
                end
            end
        end
    end

    // Assertions
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    property p_reg_default;
        (ce && soft_clear) |=> (mode_reg.regulator_disable_select == 1'b0 && block_reg == '0);
    endproperty
    a_reg_default: assert property (p_reg_default) else $error("registers not defaulted");

    property p_reg_off;
        (ce && power_state != APM_ZERO && mode_reg.regulator_disable_select) |-> ##1 (!ce || !ctrl_out.regulator_enable);
    endproperty
    a_reg_off: assert property (p_reg_off) else $error("regulator on while disabled");

    property p_pump_off;
        ctrl_out.regulator_enable |-> !ctrl_out.charge_pump_enable;
    endproperty
    a_pump_off: assert property (p_pump_off) else $error("pump on in regulator mode");

    property p_bypass;
        ctrl_out.bypass_switch_close |-> (power_state != APM_OPER && !ctrl_out.regulator_enable);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass in wrong state");

    property p_hpc;
        ctrl_out.headphone_common_output |-> (ctrl_out.hp_left_enable || ctrl_out.hp_right_enable);
    endproperty
    a_hpc: assert property (p_hpc) else $error("common driver without headphone");

    property p_mono;
        (ctrl_out.right_sample_discard) |-> (!ctrl_out.dac_right_enable && ctrl_out.right_hp_from_left);
    endproperty
    a_mono: assert property (p_mono) else $error("mono routing wrong");

    property p_state_map;
        (ce && mode_reg.power_state_field == 2'h3) |=> (power_state == APM_ZERO);
    endproperty
    a_state_map: assert property (p_state_map) else $error("unused code not zero power");

    property p_zero_off;
        (power_state == APM_ZERO) |-> (!ctrl_out.reference_bias_enable && !ctrl_out.dac_left_enable
            && !ctrl_out.hp_left_enable && !ctrl_out.regulator_enable && !ctrl_out.charge_pump_enable);
    endproperty
    a_zero_off: assert property (p_zero_off) else $error("block on in zero power");

    property p_standby;
        (power_state == APM_STANDBY) |-> (ctrl_out.reference_bias_enable && !ctrl_out.speaker_enable
            && !ctrl_out.hp_right_enable && !ctrl_out.headphone_common_output);
    endproperty
    a_standby: assert property (p_standby) else $error("standby enables wrong");

    property p_oper_pass;
        (ce && state_next == APM_OPER) |=> (!ce || ctrl_out.speaker_enable == $past(block_reg.speaker_sel));
    endproperty
    a_oper_pass: assert property (p_oper_pass) else $error("block control not transparent");

    property p_keep;
        (ce && !soft_clear && !wr_block) |=> (block_reg == $past(block_reg));
    endproperty
    a_keep: assert property (p_keep) else $error("block register changed");

    property p_rd_once;
        (!$past(reg_rd)) |-> (reg_rdata == '0);
    endproperty
    a_rd_once: assert property (p_rd_once) else $error("read data outside slot");

    c_standby: cover property (power_state == APM_ZERO ##[1:50] power_state == APM_STANDBY);
    c_oper: cover property (power_state == APM_STANDBY ##[1:50] power_state == APM_OPER);
    c_mono_hp: cover property (ctrl_out.right_hp_from_left && ctrl_out.hp_right_enable);
    c_bypass: cover property (ctrl_out.bypass_switch_close && power_state == APM_STANDBY);

endmodule

`default_nettype wire

// File: apm_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// Host controller model: drives the register port and the reset pin
module apm_host_model
    import apm_pkg::*;
#(
    parameter int SETTLE_CYC = 16
) (
    input wire logic core_clk,
    input wire logic [7:0] reg_rdata,
    output logic [3:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic hardware_reset_pin_n
);
    // Idle bus; reset pin pulled low from power-up
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        hardware_reset_pin_n = 1'b0;
    end

    // One-cycle write; released data shows its inverse
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask

    // One-cycle read; data sampled in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Reset pin held low for n cycles, then released and let through the filter
    task automatic pin_reset(input int n);
        @(posedge core_clk);
        hardware_reset_pin_n <= 1'b0;
        repeat (n) @(posedge core_clk);
        hardware_reset_pin_n <= 1'b1;
        repeat (6) @(posedge core_clk);
    endtask

    // Mode bits set in zero power, standby, settle, then operational
    task automatic power_up(input logic [7:0] m, input logic [7:0] blk);
        wr(APM_MODE_OFS, {m[7:2], APM_PS_ZERO});
        wr(APM_BLOCK_OFS, blk);
        wr(APM_MODE_OFS, {m[7:2], APM_PS_STANDBY});
        repeat (SETTLE_CYC) @(posedge core_clk);
        wr(APM_MODE_OFS, {m[7:2], APM_PS_OPER});
    endtask
endmodule

`default_nettype wire

// File: testbench.sv
`timescale 1ns/100ps
`default_nettype none

// Self-checking bench for the power mode controller
module testbench
    import apm_pkg::*;
;
    logic core_clk, rst_n, ce, hardware_reset_pin_n, reg_wr, reg_rd;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rv;
    apm_ctrl_s ctrl_out;
    apm_state_e power_state;
    int fails = 0;
    int checks = 0;
    int cycles = 0;

    // Device under test
    apm_power_ctrl u_apm_power_ctrl (.core_clk(core_clk), .rst_n(rst_n), .ce(ce),
        .hardware_reset_pin_n(hardware_reset_pin_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ctrl_out(ctrl_out),
        .power_state(power_state));

    // Host on the far side
    apm_host_model u_apm_host_model (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .hardware_reset_pin_n(hardware_reset_pin_n));

    // Clock at 8 ns period
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Cycle ceiling against hangs
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            end_sim();
        end
    end

    // Compare helpers, one per result kind
    task automatic cmp_ctrl(input string n, input apm_ctrl_s e, input apm_ctrl_s g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmp_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmp_state(input string n, input apm_state_e e, input apm_state_e g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("FAIL %s expected %0d seen %0d", n, e, g);
        end
    endtask

    // Expected decoded state; the spare code falls back to zero power
    function automatic apm_state_e exp_state(input logic [1:0] f);
        if (f == APM_PS_STANDBY) return APM_STANDBY;
        if (f == APM_PS_OPER) return APM_OPER;
        return APM_ZERO;
    endfunction

    // Expected block enables for a mode and block setting
    function automatic apm_ctrl_s exp_ctrl(input apm_mode_s m, input apm_block_s b);
        apm_ctrl_s c;
        logic op;
        c = APM_CTRL_OFF;
        op = (m.power_state_field == APM_PS_OPER);
        c.bypass_switch_close = m.regulator_bypass && !op;
        if (op || m.power_state_field == APM_PS_STANDBY) begin
            c.reference_bias_enable = 1'b1;
            c.regulator_enable = !m.regulator_disable_select && !c.bypass_switch_close;
            c.charge_pump_enable = m.regulator_disable_select;
        end
        if (op) begin
            c.dac_left_enable = b.dac_sel;
            c.dac_right_enable = b.dac_sel && !m.mono_select;
            c.right_sample_discard = m.mono_select;
            c.right_hp_from_left = m.mono_select;
            c.ain_enable = b.ain_sel;
            c.aux_enable = b.aux_sel;
            c.speaker_enable = b.speaker_sel;
            c.earpiece_enable = b.earpiece_sel;
            c.hp_left_enable = b.hp_left_sel;
            c.hp_right_enable = b.hp_right_sel;
            c.headphone_common_output = b.headphone_common_enable && (b.hp_left_sel || b.hp_right_sel);
        end
        return c;
    endfunction

    // Outputs, state and status register against the expected setting
    task automatic check(input logic [7:0] m, input logic [7:0] b);
        apm_ctrl_s c;
        logic [7:0] s, st;
        c = exp_ctrl(m, b);
        st = {c.reference_bias_enable, c.charge_pump_enable, c.bypass_switch_close, c.regulator_enable,
              2'b00, 2'(exp_state(m[1:0]))};
        repeat (2) @(posedge core_clk);
        #1;
        cmp_ctrl("ctrl_out", c, ctrl_out);
        cmp_state("power_state", exp_state(m[1:0]), power_state);
        u_apm_host_model.rd(APM_STATUS_OFS, s);
        cmp_byte("status", st, s);
    endtask

    // Write both registers, then check
    task automatic set(input logic [7:0] m, input logic [7:0] b);
        u_apm_host_model.wr(APM_MODE_OFS, m);
        u_apm_host_model.wr(APM_BLOCK_OFS, b);
        check(m, b);
    endtask

    // Both registers read back as given
    task automatic regs(input logic [7:0] m, input logic [7:0] b);
        u_apm_host_model.rd(APM_MODE_OFS, rv);
        cmp_byte("mode", m, rv);
        u_apm_host_model.rd(APM_BLOCK_OFS, rv);
        cmp_byte("block", b, rv);
    endtask

    // Defaults after reset, unmapped read gives zero
    task automatic t_reset();
        check(8'h00, 8'h00);
        regs(8'h00, 8'h00);
        u_apm_host_model.rd(4'h2, rv);
        cmp_byte("unmapped", 8'h00, rv);
        $display("test reset done");
    endtask

    // Zero power: only the bypass acts, spare code is zero power
    task automatic t_zero();
        set(8'h08, 8'hFF);
        set(8'h0B, 8'hFF);
        regs(8'h0B, 8'hFF);
        $display("test zero done");
    endtask

    // Standby over all regulator and bypass combinations
    task automatic t_standby();
        logic [7:0] ms [4] = '{8'h01, 8'h05, 8'h09, 8'h0D};
        foreach (ms[i]) set(ms[i], 8'hFF);
        $display("test standby done");
    endtask

    // Operational paths, bypass ignored, common driver, mono routing
    task automatic t_oper();
        u_apm_host_model.power_up(8'h08, 8'hE5);
        check(8'h0A, 8'hE5);
        set(8'h06, 8'h40);
        set(8'h12, 8'hFF);
        set(8'h02, 8'h80);
        set(8'h12, 8'hA3);
        $display("test oper done");
    endtask

    // Power down keeps registers; reset register clears them
    task automatic t_down();
        u_apm_host_model.wr(APM_MODE_OFS, 8'h10);
        check(8'h10, 8'hA3);
        regs(8'h10, 8'hA3);
        u_apm_host_model.wr(APM_RESET_OFS, 8'h5A);
        regs(8'h00, 8'h00);
        u_apm_host_model.rd(APM_RESET_OFS, rv);
        cmp_byte("reset_reg", 8'h00, rv);
        check(8'h00, 8'h00);
        $display("test down done");
    endtask

    // Reset pin in mid-run restores defaults
    task automatic t_pin();
        set(8'h05, 8'h3C);
        u_apm_host_model.pin_reset(8);
        regs(8'h00, 8'h00);
        check(8'h00, 8'h00);
        $display("test pin done");
    endtask

    // Clock enable low: a write strobe is not taken
    task automatic t_ce();
        @(posedge core_clk);
        ce <= 1'b0;
        u_apm_host_model.wr(APM_MODE_OFS, 8'h01);
        ce <= 1'b1;
        regs(8'h00, 8'h00);
        check(8'h00, 8'h00);
        $display("test ce done");
    endtask

    // Counts and verdict
    task automatic end_sim();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        u_apm_host_model.pin_reset(6);
        t_reset();
        t_zero();
        t_standby();
        t_oper();
        t_down();
        t_pin();
        t_ce();
        end_sim();
    end
endmodule

`default_nettype wire
